// ---- rtl/emb_ram_pkg.sv ----
// Shared constants, types and register map of the configurable embedded memory block
package emb_ram_pkg;

    // Storage geometry: 256 rows of 16 bits hold every shape
    localparam int TOTAL_BITS = 4096;   // Whole capacity in bits
    localparam int WORD_W     = 16;     // Widest data path
    localparam int ROWS       = 256;    // Physical rows of the array
    localparam int ROW_W      = 8;      // Row index width
    localparam int ADDR_W     = 11;     // Address width of the deepest shape
    localparam int CFG_W      = 11;     // Width of the control register

    // Depth and width shapes
    typedef enum logic [1:0] {
        SHAPE_256X16  = 2'b00,
        SHAPE_512X8   = 2'b01,
        SHAPE_1024X4  = 2'b10,
        SHAPE_2048X2  = 2'b11
    } shape_t;

    // Control register layout, bit 0 upward from shape
    typedef struct packed {
        logic   rdEnByp;      // Bit 10: read enable unregistered
        logic   rdAddrByp;    // Bit 9: read address unregistered
        logic   wrEnByp;      // Bit 8: write enable unregistered
        logic   wrAddrByp;    // Bit 7: write address unregistered
        logic   dOutByp;      // Bit 6: data output unregistered
        logic   dInByp;       // Bit 5: data input unregistered
        logic   romMode;      // Bit 4: lookup table, user writes blocked
        logic   ioClocking;   // Bit 3: input regs on write ce, output on read ce
        logic   dualPort;     // Bit 2: separate read address
        shape_t shape;        // Bits 1:0
    } cfg_t;

    // Register byte offsets on the bus
    localparam logic [7:0] CTRL_OFS      = 8'h00;
    localparam logic [7:0] LOAD_ADDR_OFS = 8'h04;
    localparam logic [7:0] LOAD_DATA_OFS = 8'h08;
    localparam logic [7:0] STATUS_OFS    = 8'h0c;

    // Reset values and field positions
    localparam logic [CFG_W-1:0] CFG_RESET   = 11'h000;
    localparam logic [ROW_W-1:0] LOAD_RESET  = 8'h00;
    localparam int               BLOCKED_BIT = 16;

    // Write section request from user logic
    typedef struct packed {
        logic [ADDR_W-1:0] addr;   // Word address in the active shape
        logic [WORD_W-1:0] data;   // Write data, low bits used
        logic              en;     // Write enable
        logic              ce;     // Write section clock enable
    } wr_req_t;

    // Read section request from user logic
    typedef struct packed {
        logic [ADDR_W-1:0] addr;   // Read address (dual-port only)
        logic              en;     // Read enable
        logic              ce;     // Read section clock enable
    } rd_req_t;

    // Complete state of the top module
    typedef struct packed {
        cfg_t              cfg;       // Control register
        logic [ROW_W-1:0]  loadAddr;  // Preload row pointer
        logic              blocked;   // Sticky: user write hit a lookup table
        logic [ADDR_W-1:0] wrAddrQ;   // Write address register
        logic [WORD_W-1:0] wrDataQ;   // Data input register
        logic              wrEnQ;     // Write enable register
        logic [ADDR_W-1:0] rdAddrQ;   // Read address register
        logic              rdEnQ;     // Read enable register
        logic [WORD_W-1:0] rdHold;    // Last read word while read disabled
        logic [WORD_W-1:0] rdPipe;    // Data output register
        logic [WORD_W-1:0] rdData;    // Output port flop
        logic [7:0]        dAddr;     // Bus data-phase address
        logic              dValid;    // Bus data phase pending
        logic              dWrite;    // Bus data phase is a write
        logic [31:0]       hrdata;    // Bus read data flop
        logic              hready;    // Bus ready flop
    } state_t;

endpackage : emb_ram_pkg

// ---- rtl/shape_map.sv ----
// Address to row and bit lane mapping for the selected memory shape
`timescale 1ns/1ps
module shape_map
    import emb_ram_pkg::*;
(
    input  wire shape_t              shape,
    input  wire logic [ADDR_W-1:0]   addr,
    output logic      [ROW_W-1:0]    row,
    output logic      [3:0]          bitOfs,
    output logic      [WORD_W-1:0]   laneMask
);

    // Upper address bits above the shape's width are ignored, left for cascade decoding
    always_comb begin   // RQ12
        unique case (shape)
            SHAPE_256X16: begin   // RQ14
                row      = addr[7:0];
                bitOfs   = 4'h0;
                laneMask = 16'hffff;
            end
            SHAPE_512X8: begin   // RQ14
                row      = addr[8:1];
                bitOfs   = {addr[0], 3'h0};
                laneMask = 16'h00ff;
            end
            SHAPE_1024X4: begin   // RQ14
                row      = addr[9:2];
                bitOfs   = {addr[1:0], 2'h0};
                laneMask = 16'h000f;
            end
            SHAPE_2048X2: begin   // RQ14
                row      = addr[10:3];
                bitOfs   = {addr[2:0], 1'h0};
                laneMask = 16'h0003;
            end
        endcase
    end

endmodule : shape_map

// ---- rtl/embedded_memory_block.sv ----
// Configurable embedded memory block: RAM, dual-port RAM or lookup table
//
// Functional notes
// RQ1 - Holds exactly 4,096 storage bits
// RQ2 - Shapes 256x16, 512x8, 1024x4, 2048x2
// RQ3 - Single-port and dual-port modes
// RQ4 - Write and read sections run independently
// RQ5 - Separate clock enables per section
// RQ6 - Alternative: input ce and output ce
// RQ7 - All registers clear asynchronously
// RQ8 - Write strobe generated internally from clock
// RQ9 - Six paths individually registered or bypassed
// RQ10 - Lookup table mode, preloaded, 8-in 16-out
// RQ11 - Wider memories: blocks side by side
// RQ12 - Deeper memories: cascade up to 2,048 words
// RQ13 - True two-port memory needs two blocks
// RQ14 - Address width follows selected depth
// RQ15 - Same-address read during write is undefined
//
// Our own choices: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
module embedded_memory_block
    import emb_ram_pkg::*;
(
    input  wire logic          clk,         // Single system clock, 125 MHz
    input  wire logic          rstn,        // Chip-wide clear, active low
    input  wire logic          glbClrN,     // Global clear, active low
    input  wire logic          locClrN,     // Local clear, active low
    // AHB-Lite slave
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output logic      [31:0]   hrdata,
    output logic               hreadyout,
    output logic               hresp,
    // User logic ports
    input  wire wr_req_t       wrReq,
    input  wire rd_req_t       rdReq,
    output logic [WORD_W-1:0]  rdData
);

    // Any clear source resets all control state without the clock; the array keeps its contents
    logic clrN;   // Combined asynchronous clear
    assign clrN = rstn & glbClrN & locClrN;   // RQ7

    state_t st;    // Registered state
    state_t nxt;   // Next state

    // Storage array: rows of the widest word, every shape maps onto it
    logic [WORD_W-1:0] memArr [0:ROWS-1];   // RQ1

    // Write port of the array
    logic              memWe;     // Internal write strobe
    logic [ROW_W-1:0]  memRow;    // Row written
    logic [WORD_W-1:0] memWord;   // Merged word written

    // Effective paths after the register or bypass choice
    logic [ADDR_W-1:0] wrAddrEff;   // Write address path
    logic [WORD_W-1:0] wrDataEff;   // Data input path
    logic              wrEnEff;     // Write enable path
    logic [ADDR_W-1:0] rdAddrSel;   // Read address path
    logic [ADDR_W-1:0] rdAddrEff;   // Read address after port mode
    logic              rdEnEff;     // Read enable path
    shape_t            shapeEff;    // Shape after lookup-table override

    // Shape mapping results for both sections
    logic [ROW_W-1:0]  wRow;
    logic [3:0]        wOfs;
    logic [WORD_W-1:0] wMask;
    logic [ROW_W-1:0]  rRow;
    logic [3:0]        rOfs;
    logic [WORD_W-1:0] rMask;

    // Intermediate words
    logic [WORD_W-1:0] wOld;        // Row before the merge
    logic [WORD_W-1:0] rRaw;        // Row read
    logic [WORD_W-1:0] readWord;    // Read data presented to the output stage
    logic [WORD_W-1:0] loadWord;    // Row seen by the preload window
    logic              busAcc;      // Bus address phase accepted
    logic              userWe;      // User write allowed this cycle
    logic              userTry;     // User write attempt
    logic              rdSecCe;     // Clock enable of read input registers
    logic [31:0]       busRd;       // Value for a bus read

    // Lookup table mode always reads 256 rows of 16 bits: 8 in, 16 out
    assign shapeEff = st.cfg.romMode ? SHAPE_256X16 : st.cfg.shape;   // RQ10

    // Write section mapping
    shape_map wrMap (
        .shape    (shapeEff),
        .addr     (wrAddrEff),
        .row      (wRow),
        .bitOfs   (wOfs),
        .laneMask (wMask)
    );

    // Read section mapping
    shape_map rdMap (
        .shape    (shapeEff),
        .addr     (rdAddrEff),
        .row      (rRow),
        .bitOfs   (rOfs),
        .laneMask (rMask)
    );

    // Array read ports: merge source, user read and preload window
    assign wOld     = memArr[wRow];
    assign rRaw     = memArr[rRow];
    assign loadWord = memArr[st.loadAddr];

    // Next-state logic for paths, bus registers and output stage
    always_comb begin
        nxt = st;

        // Register or bypass choice per path
        wrAddrEff = st.cfg.wrAddrByp ? wrReq.addr : st.wrAddrQ;   // RQ9
        wrDataEff = st.cfg.dInByp    ? wrReq.data : st.wrDataQ;   // RQ9
        wrEnEff   = st.cfg.wrEnByp   ? wrReq.en   : st.wrEnQ;     // RQ9
        rdAddrSel = st.cfg.rdAddrByp ? rdReq.addr : st.rdAddrQ;   // RQ9
        rdEnEff   = st.cfg.rdEnByp   ? rdReq.en   : st.rdEnQ;     // RQ9

        // Single-port mode shares the write address for reading
        rdAddrEff = st.cfg.dualPort ? rdAddrSel : wrAddrEff;   // RQ3

        // In input/output clocking the write ce loads every input register
        rdSecCe = st.cfg.ioClocking ? wrReq.ce : rdReq.ce;   // RQ6

        // Write section input registers follow the write clock enable
        if (wrReq.ce) begin   // RQ5
            nxt.wrAddrQ = wrReq.addr;
            nxt.wrDataQ = wrReq.data;
            nxt.wrEnQ   = wrReq.en;
        end

        // Read section input registers follow their own enable
        if (rdSecCe) begin   // RQ4
            nxt.rdAddrQ = rdReq.addr;
            nxt.rdEnQ   = rdReq.en;
        end

        // Strobe is made here from enable and ce; user only meets setup
        userTry = wrEnEff & wrReq.ce;          // RQ8
        userWe  = userTry & ~st.cfg.romMode;   // RQ10

        // Bus address phase
        busAcc = hsel & htrans[1] & hready;
        busRd  = 32'h00000000;
        unique case (haddr[7:0])
            CTRL_OFS:      busRd[CFG_W-1:0] = st.cfg;
            LOAD_ADDR_OFS: busRd[ROW_W-1:0] = st.loadAddr;
            LOAD_DATA_OFS: busRd[WORD_W-1:0] = loadWord;
            STATUS_OFS: begin
                busRd[WORD_W-1:0]  = st.rdData;
                busRd[BLOCKED_BIT] = st.blocked;
            end
            default:       busRd = 32'h00000000;   // Unmapped reads zero
        endcase
        nxt.dValid = busAcc;
        if (busAcc) begin
            nxt.dAddr  = haddr[7:0];
            nxt.dWrite = hwrite;
            if (!hwrite) begin
                nxt.hrdata = busRd;
            end
        end
        nxt.hready = 1'b1;   // Zero wait states

        // Array write port defaults to the user write
        memWe   = userWe;   // RQ8
        memRow  = wRow;   // RQ13
        memWord = (wOld & ~(wMask << wOfs)) | ((wrDataEff & wMask) << wOfs);   // RQ2

        // Bus data phase writes
        if (st.dValid && st.dWrite) begin
            unique case (st.dAddr)
                CTRL_OFS:      nxt.cfg = cfg_t'(hwdata[CFG_W-1:0]);
                LOAD_ADDR_OFS: nxt.loadAddr = hwdata[ROW_W-1:0];
                LOAD_DATA_OFS: begin   // RQ10
                    // Preload wins the port; a colliding user write is lost
                    memWe        = 1'b1;
                    memRow       = st.loadAddr;
                    memWord      = hwdata[WORD_W-1:0];
                    nxt.loadAddr = st.loadAddr + 8'h01;
                end
                STATUS_OFS: begin
                    if (hwdata[BLOCKED_BIT]) begin
                        nxt.blocked = 1'b0;
                    end
                end
                default: begin
                    // Unmapped writes are ignored
                end
            endcase
        end

        // A blocked attempt in the clearing cycle still sets the flag
        if (userTry && st.cfg.romMode) begin
            nxt.blocked = 1'b1;
        end

        // Read is old data on a same-row write; callers must not rely on it
        if (rdEnEff) begin   // RQ15
            readWord = (rRaw >> rOfs) & rMask;   // RQ2
        end else begin
            readWord = st.rdHold;
        end
        nxt.rdHold = readWord;

        // Output register runs on the read (output) clock enable
        if (rdReq.ce) begin   // RQ6
            nxt.rdPipe = readWord;
        end

        // Bypassed output still leaves through the port flop
        nxt.rdData = st.cfg.dOutByp ? readWord : st.rdPipe;   // RQ9
    end

    // Every register of the block clears without the clock
    always_ff @(posedge clk or negedge clrN) begin
        if (!clrN) begin   // RQ7
            st          <= '0;
            st.cfg      <= cfg_t'(CFG_RESET);
            st.loadAddr <= LOAD_RESET;
            st.hready   <= 1'b1;
        end else begin
            st <= nxt;
        end
    end

    // Array contents survive clears; they are storage, not control state
    always_ff @(posedge clk) begin
        if (memWe) begin   // RQ8
            memArr[memRow] <= memWord;
        end
    end

    // Outputs come straight from flops; hresp is tied low
    assign hrdata    = st.hrdata;
    assign hreadyout = st.hready;
    assign hresp     = 1'b0;
    assign rdData    = st.rdData;   // RQ11

endmodule : embedded_memory_block

// ---- verif/emb_ram_properties.sv ----
// Port-level assertions for the embedded memory block
`timescale 1ns/1ps
module emb_ram_properties
    import emb_ram_pkg::*;
(
    input wire logic              clk,
    input wire logic              rstn,
    input wire logic              glbClrN,
    input wire logic              locClrN,
    input wire logic              hsel,
    input wire logic [31:0]       haddr,
    input wire logic [1:0]        htrans,
    input wire logic              hwrite,
    input wire logic              hready,
    input wire logic [31:0]       hrdata,
    input wire logic              hreadyout,
    input wire logic              hresp,
    input wire wr_req_t           wrReq,
    input wire rd_req_t           rdReq,
    input wire logic [WORD_W-1:0] rdData
);
    // Any of the three clear sources
    wire clrN  = rstn & glbClrN & locClrN;
    // Bus read taken at this edge
    wire rdAcc = hsel & htrans[1] & hready & ~hwrite;
    // Nothing that could move the output; five such cycles flush every pipe stage
    wire quiet = ~rdReq.ce & ~wrReq.ce & ~(hsel & htrans[1]);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!clrN);

    reset_release_a: assert property ($rose(rstn) |-> rdData == '0 && hrdata == '0)
        else $error("outputs not clear after reset");
    global_clear_a: assert property (disable iff (!rstn) !glbClrN |-> rdData == '0 && hrdata == '0)
        else $error("global clear did not clear outputs");
    local_clear_a: assert property (disable iff (!rstn) !locClrN |-> rdData == '0 && hrdata == '0)
        else $error("local clear did not clear outputs");
    output_hold_a: assert property ((quiet && $stable(rdReq) && $stable(wrReq))[*5] |=> $stable(rdData))
        else $error("read data moved with both enables low");
    status_mirror_a: assert property (rdAcc && haddr[7:0] == STATUS_OFS |=> hrdata[15:0] == $past(rdData))
        else $error("status does not mirror read data");
    unmapped_zero_a: assert property (rdAcc && haddr[7:0] > STATUS_OFS |=> hrdata == '0)
        else $error("unmapped read not zero");
    read_stands_a: assert property (!rdAcc |=> $stable(hrdata))
        else $error("bus read data changed without a read");
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus slave stalled or errored");
    upper_zero_a: assert property (rdAcc |=> hrdata[31:17] == '0)
        else $error("unused register bits not zero");

    cover property (rdAcc);
    cover property (wrReq.ce && wrReq.en);
    cover property (rdReq.ce && rdReq.en);
endmodule : emb_ram_properties

// ---- verif/user_logic_model.sv ----
// Model of the user logic that drives the write and read sections
`timescale 1ns/1ps
module user_logic_model
    import emb_ram_pkg::*;
(
    input  wire logic [WORD_W-1:0] rdData,
    input  wire logic              clk,
    output wr_req_t                wrReq,
    output rd_req_t                rdReq
);
    logic              slow = 1'b0;  // Stall: enables only every other cycle
    logic              tick = 1'b0;  // Stall phase
    logic [ADDR_W-1:0] wa   = '0;    // Write address
    logic [ADDR_W-1:0] ra   = '0;    // Read address
    logic [WORD_W-1:0] wd   = '0;    // Write data
    logic              we   = 1'b0;  // Write enable
    logic              re   = 1'b0;  // Read enable
    logic              on   = 1'b0;  // Sections enabled
    logic              rdCeOff = 1'b0;  // Read section clock enable held low
    logic              wrCeOff = 1'b0;  // Write section clock enable held low

    // Stall phase flips after every edge
    always @(posedge clk) tick <= ~tick;

    // Requests held whole; clock enables gated by the stall pattern
    assign wrReq = '{addr: wa, data: wd, en: we, ce: on & ~wrCeOff & (~slow | tick)};
    assign rdReq = '{addr: ra, en: re, ce: on & ~rdCeOff & (~slow | tick)};

    // Wait n enabled cycles; stalls double the wait
    task automatic hold(input int n);
        repeat (slow ? 2 * n : n) @(posedge clk);
    endtask : hold

    // One word written; enable spans two enabled edges, then flush
    task automatic memWrite(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
        wa <= a;
        wd <= d;
        we <= 1'b1;
        on <= 1'b1;
        hold(2);
        we <= 1'b0;
        hold(6);
        on <= 1'b0;
        @(posedge clk);
    endtask : memWrite

    // Read only after writes finished, never at a live write address
    task automatic memRead(input logic [ADDR_W-1:0] w, input logic [ADDR_W-1:0] r,
                           output logic [WORD_W-1:0] q);
        wa <= w;
        ra <= r;
        re <= 1'b1;
        on <= 1'b1;
        hold(6);
        q = rdData;
        re <= 1'b0;
        on <= 1'b0;
        @(posedge clk);
    endtask : memRead
endmodule : user_logic_model

// ---- verif/tb_top.sv ----
// Self-checking bench for the embedded memory block
`timescale 1ns/1ps
module tb_top
    import emb_ram_pkg::*;
;
    logic              clk     = 1'b0;  // 125 MHz
    logic              rstn    = 1'b0;  // Chip-wide clear
    logic              glbClrN = 1'b1;  // Global clear
    logic              locClrN = 1'b1;  // Local clear
    logic              hsel    = 1'b0;
    logic              hwrite  = 1'b0;
    logic [1:0]        htrans  = 2'h0;
    logic [31:0]       haddr   = '0;
    logic [31:0]       hwdata  = '0;
    logic [31:0]       hrdata;
    logic [31:0]       q;               // Last bus read word
    logic              hreadyout;
    logic              hresp;
    wr_req_t           wrReq;
    rd_req_t           rdReq;
    logic [WORD_W-1:0] rdData;
    int                num_errors   = 0;
    int                total_checks = 0;
    int                cycles       = 0;

    // Clock
    initial forever #4 clk = ~clk;

    embedded_memory_block uut (.clk(clk), .rstn(rstn), .glbClrN(glbClrN), .locClrN(locClrN),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .wrReq(wrReq), .rdReq(rdReq), .rdData(rdData));

    user_logic_model usr (.rdData(rdData), .clk(clk), .wrReq(wrReq), .rdReq(rdReq));

    // Compare and count
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // One single word transfer; the idle edge after it keeps read-after-write safe
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h0, a};
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        q = hrdata;
        @(posedge clk);
    endtask : ahb

    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input string what);
        ahb(1'b0, a, 32'h0);
        check(what, exp, q);
    endtask : rdChk

    task automatic memChk(input logic [10:0] w, input logic [10:0] r, input logic [15:0] exp,
                          input string what);
        logic [15:0] m;
        usr.memRead(w, r, m);
        check(what, {16'h0, exp}, {16'h0, m});
    endtask : memChk

    task automatic testReset();
        rdChk(CTRL_OFS, 32'h0, "ctrl");
        rdChk(LOAD_ADDR_OFS, 32'h0, "load addr");
        rdChk(STATUS_OFS, 32'h0, "status");
        rdChk(8'h10, 32'h0, "unmapped");
        $display("test reset done");
    endtask : testReset

    // Every shape: narrow words keep only their own lane
    task automatic testShapes();
        logic [15:0] msk;
        for (int s = 0; s < 4; s++) begin
            msk = 16'hffff >> (16 - (16 >> s));
            ahb(1'b1, CTRL_OFS, s);
            usr.memWrite(11'h5, 16'h9a6c);
            usr.memWrite(11'h6, 16'h3b15);
            memChk(11'h5, 11'h5, 16'h9a6c & msk, "shape low word");
            memChk(11'h6, 11'h6, 16'h3b15 & msk, "shape next word");
        end
        usr.memWrite(11'h7ff, 16'h0002);
        memChk(11'h7ff, 11'h7ff, 16'h0002, "deepest word");
        check("upper lanes", 32'h0, {18'h0, rdData[15:2]});
        $display("test shapes done");
    endtask : testShapes

    // Separate read address, user side stalling
    task automatic testDual();
        ahb(1'b1, CTRL_OFS, 32'h4);
        usr.slow <= 1'b1;
        usr.memWrite(11'h21, 16'hc0de);
        memChk(11'h40, 11'h21, 16'hc0de, "dual read");
        usr.slow <= 1'b0;
        $display("test dual done");
    endtask : testDual

    // All six paths unregistered
    task automatic testBypass();
        ahb(1'b1, CTRL_OFS, 32'h7e0);
        usr.memWrite(11'h33, 16'h5aa5);
        memChk(11'h33, 11'h33, 16'h5aa5, "bypass");
        ahb(1'b1, CTRL_OFS, 32'h7e4);
        memChk(11'h0, 11'h33, 16'h5aa5, "bypass dual");
        $display("test bypass done");
    endtask : testBypass

    // Preloaded lookup table refuses user writes
    task automatic testRom();
        ahb(1'b1, LOAD_ADDR_OFS, 32'h3);
        for (int i = 0; i < 4; i++) ahb(1'b1, LOAD_DATA_OFS, 32'h1e00 + 32'h10 * i);
        rdChk(LOAD_ADDR_OFS, 32'h7, "load pointer");
        ahb(1'b1, CTRL_OFS, 32'h10);
        for (int i = 0; i < 4; i++) memChk(11'(i + 3), 11'(i + 3), 16'(32'h1e00 + 32'h10 * i), "table");
        usr.memWrite(11'h3, 16'hffff);
        memChk(11'h3, 11'h3, 16'h1e00, "table kept");
        rdChk(STATUS_OFS, 32'h11e00, "blocked");
        ahb(1'b1, STATUS_OFS, 32'h10000);
        rdChk(STATUS_OFS, 32'h01e00, "blocked cleared");
        $display("test table done");
    endtask : testRom

    // Input regs on the write ce, output reg on the read ce; sections stall apart
    task automatic testClocking();
        ahb(1'b1, CTRL_OFS, 32'hc);
        usr.memWrite(11'h50, 16'h4a4a);
        usr.memWrite(11'h51, 16'hb5b5);
        memChk(11'h0, 11'h50, 16'h4a4a, "io clocking read");
        usr.rdCeOff <= 1'b1;
        memChk(11'h0, 11'h51, 16'h4a4a, "output ce held");
        usr.rdCeOff <= 1'b0;
        usr.wrCeOff <= 1'b1;
        memChk(11'h0, 11'h50, 16'hb5b5, "input regs on write ce");
        ahb(1'b1, CTRL_OFS, 32'h4);
        memChk(11'h0, 11'h50, 16'h4a4a, "read ce alone");
        usr.wrCeOff <= 1'b0;
        $display("test clocking done");
    endtask : testClocking

    // Global then local clear in mid-run
    task automatic testClear();
        ahb(1'b1, CTRL_OFS, 32'h4);
        glbClrN <= 1'b0;
        repeat (2) @(posedge clk);
        glbClrN <= 1'b1;
        @(posedge clk);
        check("output after clear", 32'h0, {16'h0, rdData});
        rdChk(CTRL_OFS, 32'h0, "global clear");
        ahb(1'b1, CTRL_OFS, 32'h4);
        locClrN <= 1'b0;
        repeat (2) @(posedge clk);
        locClrN <= 1'b1;
        @(posedge clk);
        rdChk(CTRL_OFS, 32'h0, "local clear");
        $display("test clear done");
    endtask : testClear

    // Verdict and end of run
    task automatic results();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : results

    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        testReset();
        testShapes();
        testDual();
        testBypass();
        testRom();
        testClocking();
        testClear();
        results();
    end

    // Hang guard, far above the few hundred cycles the tests need
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            results();
        end
    end
endmodule : tb_top

bind embedded_memory_block emb_ram_properties chk (.clk(clk), .rstn(rstn), .glbClrN(glbClrN),
    .locClrN(locClrN), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .wrReq(wrReq),
    .rdReq(rdReq), .rdData(rdData));
